// ==== rtl/rt_legality_and_backend_port.sv ====
// Command legality interface and backend memory port with request FIFO
`timescale 1ns/1ps
// How it works
// - Legality select low: internal check passes every mode code and sub-address.
// - Legality select high: verdict comes only from the external legal input.
// - Active command: broadcast bit 11, transmit bit 10, sub-address 9:5, count 4:0.
// - Active command stays stable for the whole message.
// - Address-map latch enable pulses when a new active command is loaded.
// - Vector latch enable pulses once the command is judged legal.
// - Backend port runs in synchronous or asynchronous strobe mode.
// - Synchronous write strobe: data and address written at the rising edge.
// - Asynchronous write: one clock setup, strobe stretched by wait, one clock hold.
// - Synchronous read strobe: data sampled at the following rising edge.
// - Wait low in asynchronous mode stretches the current strobe.
// - Asynchronous read: setup and hold one clock, data taken as strobe rises.
// - Access type code: 00 data, 01 status word, 10 command; 11 never.
// - Timeout flag rises when an access is not finished in time.

////////////////////////////////////////////////////////////////////////////////
module request_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    // Pointer wrap trick only works for power-of-two depths
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("request_fifo: depth must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wr_ptr, rd_ptr;
    logic push, pop;
    assign out_valid = wr_ptr != rd_ptr;
    assign in_ready = (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]) || (wr_ptr[PW] == rd_ptr[PW]);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr[PW-1:0]];
    always_ff @(posedge clock) begin
        if (push) begin
            store[wr_ptr[PW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module rt_legality_and_backend_port
    import rt_backend_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic use_external_legality,
    input wire logic command_legal_in,
    input wire logic asynchronous_mode,
    input wire logic command_strobe,
    input wire logic [11:0] command_in,
    input wire logic message_done,
    output logic [11:0] active_command_word,
    output logic address_map_latch_enable,
    output logic vector_latch_enable,
    output logic command_accepted,
    output logic command_rejected,
    input wire logic access_valid,
    output logic access_ready,
    input wire logic access_write,
    input wire logic [1:0] access_type,
    input wire logic [10:0] access_address,
    input wire logic [15:0] access_data,
    output logic [15:0] read_data,
    output logic read_valid,
    input wire logic clear_failure,
    output logic backend_request_n,
    input wire logic backend_grant_n,
    input wire logic backend_wait_n,
    output logic backend_write_strobe_n,
    output logic backend_read_strobe_n,
    output logic [10:0] backend_address,
    output logic [15:0] backend_data_out,
    input wire logic [15:0] backend_data_in,
    output logic [1:0] access_type_code,
    output logic backend_timeout_flag
);
    ////////////////////////////////////////////////////////////////////////////
    // Straps and the external verdict arrive from pins
    logic [2:0] pin_meta, pin_sync;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {asynchronous_mode, command_legal_in, use_external_legality};
            pin_sync <= pin_meta;
        end
    end
    logic external_sel, external_ok, async_sel;
    assign external_sel = pin_sync[0];
    assign external_ok = pin_sync[1];
    assign async_sel = pin_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    legality_state_t lg_state;
    logic [4:0] settle;
    logic take_command, verdict;
    assign take_command = command_strobe && lg_state == LG_IDLE;
    assign verdict = external_sel ? external_ok : 1'b1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active_command_word <= CMD_RESET;
        end else if (take_command) begin
            active_command_word <= command_in;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lg_state <= LG_IDLE;
            settle <= 5'h00;
        end else begin
            case (lg_state)
                LG_IDLE: begin
                    settle <= 5'h00;
                    if (command_strobe) begin
                        lg_state <= LG_WAIT;
                    end
                end
                LG_WAIT: begin
                    settle <= settle + 5'h01;
                    // Internal check needs no settling; external gets the full window
                    if (!external_sel || 32'(settle) >= LEGAL_SETTLE_CYCLES - 1) begin
                        lg_state <= verdict ? LG_LEGAL : LG_ILLEGAL;
                    end
                end
                LG_LEGAL, LG_ILLEGAL: begin
                    if (message_done) begin
                        lg_state <= LG_IDLE;
                    end
                end
                default: lg_state <= LG_IDLE;
            endcase
        end
    end

    logic judged;
    assign judged = lg_state == LG_WAIT && (!external_sel
        || 32'(settle) >= LEGAL_SETTLE_CYCLES - 1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            address_map_latch_enable <= 1'b0;
            vector_latch_enable <= 1'b0;
            command_accepted <= 1'b0;
            command_rejected <= 1'b0;
        end else begin
            address_map_latch_enable <= take_command;
            vector_latch_enable <= judged && verdict;
            command_accepted <= judged && verdict;
            command_rejected <= judged && !verdict;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests of a rejected message are swallowed so the core never hangs
    logic fifo_in_ready, fifo_push, fifo_valid, fifo_pop;
    logic [REQ_WIDTH-1:0] fifo_out;
    assign fifo_push = access_valid && lg_state == LG_LEGAL;
    assign access_ready = (lg_state == LG_LEGAL && fifo_in_ready) || lg_state == LG_ILLEGAL;

    request_fifo #(.WIDTH(REQ_WIDTH), .DEPTH(FIFO_DEPTH)) requests (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({access_write, access_type, access_address, access_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    backend_state_t be_state;
    logic is_write;
    logic [TIMER_WIDTH-1:0] timer;
    logic expired;
    logic granted;
    assign granted = !backend_grant_n;
    assign fifo_pop = be_state == BE_IDLE && fifo_valid;
    assign expired = 32'(timer) >= ACCESS_LIMIT_CYCLES - 1;
    assign backend_request_n = be_state == BE_IDLE;
    // Strobes gated by the live grant so a withdrawn grant ends drive at once
    assign backend_write_strobe_n = !(be_state == BE_STROBE && is_write && granted);
    assign backend_read_strobe_n = !(be_state == BE_STROBE && !is_write && granted);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            be_state <= BE_IDLE;
        end else if (be_state != BE_IDLE && expired) begin
            be_state <= BE_IDLE;
        end else begin
            case (be_state)
                BE_IDLE: begin
                    if (fifo_valid) begin
                        be_state <= BE_REQUEST;
                    end
                end
                BE_REQUEST: begin
                    if (granted) begin
                        be_state <= async_sel ? BE_SETUP : BE_STROBE;
                    end
                end
                BE_SETUP: be_state <= BE_STROBE;
                BE_STROBE: begin
                    if (granted && (!async_sel || backend_wait_n)) begin
                        be_state <= BE_HOLD;
                    end
                end
                BE_HOLD: be_state <= BE_IDLE;
                default: be_state <= BE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer <= '0;
        end else if (be_state == BE_IDLE) begin
            timer <= '0;
        end else begin
            timer <= timer + 1'b1;
        end
    end

    // Address, data and type stay put from the request through the hold clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            is_write <= 1'b0;
            access_type_code <= ACCESS_DATA;
            backend_address <= ADDR_RESET;
            backend_data_out <= DATA_RESET;
        end else if (fifo_pop) begin
            is_write <= fifo_out[REQ_WIDTH-1];
            // Unused code folds onto data so it never reaches the pins
            access_type_code <= fifo_out[REQ_WIDTH-2 -: 2] == 2'h3 ? ACCESS_DATA
                : fifo_out[REQ_WIDTH-2 -: 2];
            backend_address <= fifo_out[DATA_WIDTH +: ADDR_WIDTH];
            backend_data_out <= fifo_out[DATA_WIDTH-1:0];
        end
    end

    logic strobe_ends;
    assign strobe_ends = be_state == BE_STROBE && granted && backend_wait_n && !expired;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= DATA_RESET;
            read_valid <= 1'b0;
        end else begin
            read_valid <= 1'b0;
            if (!is_write && async_sel && strobe_ends) begin
                read_data <= backend_data_in;
                read_valid <= 1'b1;
            end else if (!is_write && !async_sel && be_state == BE_HOLD) begin
                read_data <= backend_data_in;
                read_valid <= 1'b1;
            end
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            backend_timeout_flag <= 1'b0;
        end else if (be_state != BE_IDLE && expired) begin
            backend_timeout_flag <= 1'b1;
        end else if (clear_failure) begin
            backend_timeout_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_command_stable: assert property (@(posedge clock) disable iff (!rst_n)
        lg_state != LG_IDLE && $past(lg_state) != LG_IDLE |-> $stable(active_command_word))
        else $error("active command changed during a message");
    a_map_latch: assert property (@(posedge clock) disable iff (!rst_n)
        take_command |=> address_map_latch_enable && active_command_word == $past(command_in))
        else $error("address map latch not pulsed with new command");
    a_internal_pass: assert property (@(posedge clock) disable iff (!rst_n)
        lg_state == LG_WAIT && !external_sel |=> lg_state == LG_LEGAL && vector_latch_enable)
        else $error("internal legality did not pass command");
    a_external_verdict: assert property (@(posedge clock) disable iff (!rst_n)
        judged && external_sel && !external_ok |=> lg_state == LG_ILLEGAL && !vector_latch_enable)
        else $error("external illegal verdict ignored");
    a_illegal_blocked: assert property (@(posedge clock) disable iff (!rst_n)
        lg_state == LG_ILLEGAL |-> !fifo_push)
        else $error("illegal command reached the backend queue");
    a_strobe_granted: assert property (@(posedge clock) disable iff (!rst_n)
        !backend_write_strobe_n || !backend_read_strobe_n |-> granted && !backend_request_n)
        else $error("strobe driven without grant");
    a_async_setup: assert property (@(posedge clock) disable iff (!rst_n)
        async_sel && $rose(be_state == BE_STROBE) |-> $past(be_state) == BE_SETUP
        && $stable(backend_address))
        else $error("asynchronous strobe without setup clock");
    a_wait_stretch: assert property (@(posedge clock) disable iff (!rst_n)
        async_sel && be_state == BE_STROBE && !backend_wait_n && !expired
        |=> be_state == BE_STROBE)
        else $error("wait did not stretch strobe");
    a_timeout_flag: assert property (@(posedge clock) disable iff (!rst_n)
        be_state != BE_IDLE && timer == TIMER_WIDTH'(ACCESS_LIMIT_CYCLES - 1)
        |=> backend_timeout_flag && be_state == BE_IDLE)
        else $error("timeout flag not raised after access limit");
    a_type_code: assert property (@(posedge clock) disable iff (!rst_n)
        !backend_request_n |-> access_type_code != 2'h3)
        else $error("reserved access type on the pins");
endmodule

// ==== rtl/rt_backend_pkg.sv ====
// Shared constants for the command legality and backend memory port
package rt_backend_pkg;
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int LEGAL_SETTLE_NS = 2000;
    localparam int ACCESS_LIMIT_NS = 10000;
    // Verdict window rounds down; two extra cycles cover the input synchroniser
    localparam int LEGAL_SETTLE_CYCLES = (LEGAL_SETTLE_NS / CLOCK_PERIOD_NS) + 2;
    localparam int ACCESS_LIMIT_CYCLES = ACCESS_LIMIT_NS / CLOCK_PERIOD_NS;
    localparam int TIMER_WIDTH = 8;

    localparam int CMD_WIDTH = 12;
    localparam int CMD_BROADCAST_BIT = 11;
    localparam int CMD_TRANSMIT_BIT = 10;
    localparam int CMD_SUBADDR_MSB = 9;
    localparam int CMD_SUBADDR_LSB = 5;
    localparam int CMD_COUNT_MSB = 4;
    localparam int CMD_COUNT_LSB = 0;
    localparam logic [11:0] CMD_RESET = 12'h000;

    localparam int ADDR_WIDTH = 11;
    localparam int DATA_WIDTH = 16;
    localparam int REQ_WIDTH = 1 + 2 + ADDR_WIDTH + DATA_WIDTH;
    localparam int FIFO_DEPTH = 16;
    localparam logic [10:0] ADDR_RESET = 11'h000;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    localparam logic [1:0] ACCESS_DATA = 2'h0;
    localparam logic [1:0] ACCESS_STATUS = 2'h1;
    localparam logic [1:0] ACCESS_COMMAND = 2'h2;

    typedef enum logic [1:0] {
        LG_IDLE = 2'h0, LG_WAIT = 2'h1, LG_LEGAL = 2'h3, LG_ILLEGAL = 2'h2
    } legality_state_t;

    typedef enum logic [2:0] {
        BE_IDLE = 3'h0, BE_REQUEST = 3'h1, BE_SETUP = 3'h3, BE_STROBE = 3'h2,
        BE_HOLD = 3'h6
    } backend_state_t;
endpackage

// ==== verif/backend_model.sv ====
// Behavioural backend RAM with grant, wait and external legality logic
`timescale 1ns/1ps
module backend_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic asynchronous_mode,
    input wire logic grant_block,
    input wire logic [3:0] wait_cycles,
    input wire logic [4:0] illegal_subaddr,
    input wire logic [11:0] active_command_word,
    input wire logic address_map_latch_enable,
    input wire logic vector_latch_enable,
    output logic command_legal_in,
    input wire logic backend_request_n,
    output logic backend_grant_n,
    output logic backend_wait_n,
    input wire logic backend_write_strobe_n,
    input wire logic backend_read_strobe_n,
    input wire logic [10:0] backend_address,
    input wire logic [15:0] backend_data_out,
    output logic [15:0] backend_data_in,
    input wire logic [1:0] access_type_code,
    output logic [11:0] mapped_command,
    output logic [11:0] vector_command,
    output int n_writes
);
    logic [15:0] mem [0:2047];
    logic [1:0] type_mem [0:2047];
    logic [15:0] last_read;
    logic [3:0] waited;
    logic write_prev;
    logic strobing;
    logic sync_data_valid;

    assign strobing = !(backend_write_strobe_n && backend_read_strobe_n);
    // Stall only in async mode, counted from the strobe's fall
    assign backend_wait_n = !(asynchronous_mode && strobing && waited < wait_cycles);
    // Released bus shows the inverse of its last value, not a stale match
    // Sync RAM registers the word at the strobe edge and shows it one clock
    assign backend_data_in = asynchronous_mode
        ? (backend_read_strobe_n ? ~last_read : mem[backend_address])
        : (sync_data_valid ? last_read : ~last_read);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            backend_grant_n <= 1'b1;
            command_legal_in <= 1'b0;
            write_prev <= 1'b1;
            sync_data_valid <= 1'b0;
            waited <= 4'h0;
            last_read <= 16'h0000;
            n_writes <= 0;
            mapped_command <= 12'h000;
            vector_command <= 12'h000;
        end else begin
            backend_grant_n <= backend_request_n | grant_block;
            command_legal_in <= active_command_word[9:5] != illegal_subaddr;
            write_prev <= backend_write_strobe_n;
            sync_data_valid <= !backend_read_strobe_n;
            waited <= strobing ? waited + 4'h1 : 4'h0;
            if (address_map_latch_enable) begin
                mapped_command <= active_command_word;
            end
            if (vector_latch_enable) begin
                vector_command <= active_command_word;
            end
            if (!backend_read_strobe_n) begin
                last_read <= mem[backend_address];
            end
            if (asynchronous_mode ? (!write_prev && backend_write_strobe_n)
                                  : !backend_write_strobe_n) begin
                mem[backend_address] <= backend_data_out;
                type_mem[backend_address] <= access_type_code;
                n_writes <= n_writes + 1;
            end
        end
    end
endmodule

// ==== verif/rt_legality_and_backend_port_tb.sv ====
// Self-checking bench for the legality interface and backend port
`timescale 1ns/1ps
module rt_legality_and_backend_port_tb;
    import rt_backend_pkg::*;
    logic clock, rst_n, use_external_legality, command_legal_in, asynchronous_mode;
    logic command_strobe, message_done, address_map_latch_enable, vector_latch_enable;
    logic command_accepted, command_rejected, access_valid, access_ready, access_write;
    logic read_valid, clear_failure, backend_request_n, backend_grant_n, backend_wait_n;
    logic backend_write_strobe_n, backend_read_strobe_n, backend_timeout_flag, grant_block;
    logic [11:0] command_in, active_command_word, mapped_command, vector_command;
    logic [1:0] access_type, access_type_code;
    logic [10:0] access_address, backend_address;
    logic [15:0] access_data, read_data, backend_data_out, backend_data_in;
    logic [3:0] wait_cycles;
    int n_writes, mismatches, n_compared, cycles;

    rt_legality_and_backend_port dut_u (.clock, .rst_n, .use_external_legality,
        .command_legal_in, .asynchronous_mode, .command_strobe, .command_in, .message_done,
        .active_command_word, .address_map_latch_enable, .vector_latch_enable,
        .command_accepted, .command_rejected, .access_valid, .access_ready, .access_write,
        .access_type, .access_address, .access_data, .read_data, .read_valid,
        .clear_failure, .backend_request_n, .backend_grant_n, .backend_wait_n,
        .backend_write_strobe_n, .backend_read_strobe_n, .backend_address,
        .backend_data_out, .backend_data_in, .access_type_code, .backend_timeout_flag);
    backend_model model_u (.clock, .rst_n, .asynchronous_mode, .grant_block, .wait_cycles,
        .illegal_subaddr(5'h02), .active_command_word, .address_map_latch_enable,
        .vector_latch_enable, .command_legal_in, .backend_request_n, .backend_grant_n,
        .backend_wait_n, .backend_write_strobe_n, .backend_read_strobe_n, .backend_address,
        .backend_data_out, .backend_data_in, .access_type_code, .mapped_command,
        .vector_command, .n_writes);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic open_msg(input logic [11:0] cmd, input logic legal);
        command_in = cmd;
        command_strobe = 1'b1;
        tick();
        command_strobe = 1'b0;
        for (int i = 0; i < 3 && !address_map_latch_enable; i++) tick();
        check({4'h0, active_command_word}, {4'h0, cmd});
        for (int i = 0; i < 40 && !(command_accepted || command_rejected); i++) tick();
        check({14'h0, command_accepted, command_rejected}, {14'h0, legal, !legal});
        check({15'h0, vector_latch_enable}, {15'h0, legal});
        check({4'h0, mapped_command}, {4'h0, cmd});
        tick();
        if (legal) check({4'h0, vector_command}, {4'h0, cmd});
    endtask
    task automatic close_msg();
        message_done = 1'b1;
        tick();
        message_done = 1'b0;
        tick();
    endtask
    // Leaves valid high so back-to-back pushes never re-assign it in one step
    task automatic push(input logic wr, input logic [1:0] typ, input logic [10:0] addr,
                        input logic [15:0] data, input int limit, output logic ok);
        access_valid = 1'b1;
        access_write = wr;
        access_type = typ;
        access_address = addr;
        access_data = data;
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++) begin
            @(posedge clock);
            ok = access_ready;
            #1;
        end
    endtask
    task automatic read_check(input logic [10:0] addr, input logic [15:0] exp);
        logic ok;
        push(1'b0, ACCESS_DATA, addr, 16'h0000, 300, ok);
        access_valid = 1'b0;
        for (int i = 0; i < 300 && !read_valid; i++) tick();
        check(read_data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_internal();
        open_msg(12'hc45, 1'b1);
        command_in = 12'h3ff;
        command_strobe = 1'b1;
        tick();
        command_strobe = 1'b0;
        repeat (5) tick();
        check({4'h0, active_command_word}, 16'h0c45);
        close_msg();
    endtask
    task automatic t_access(input logic mode, input logic [3:0] waits, input int base);
        logic ok;
        asynchronous_mode = mode;
        wait_cycles = waits;
        repeat (3) tick();
        open_msg(12'h065, 1'b1);
        for (int i = 0; i < 3; i++) push(1'b1, 2'(i), 11'(base + i), 16'(16'ha5c0 + i), 300, ok);
        access_valid = 1'b0;
        for (int i = 0; i < 3; i++) begin
            read_check(11'(base + i), 16'(16'ha5c0 + i));
            check({14'h0, model_u.type_mem[base + i]}, {14'h0, 2'(i)});
        end
        repeat (3) tick();
        check({15'h0, backend_request_n}, 16'h0001);
        close_msg();
    endtask
    task automatic t_external();
        logic ok;
        int base;
        use_external_legality = 1'b1;
        repeat (3) tick();
        base = n_writes;
        open_msg(12'hc45, 1'b0);
        push(1'b1, ACCESS_DATA, 11'h050, 16'h1234, 300, ok);
        access_valid = 1'b0;
        repeat (20) tick();
        check(16'(n_writes - base), 16'h0000);
        check({15'h0, backend_request_n}, 16'h0001);
        close_msg();
        open_msg(12'h065, 1'b1);
        close_msg();
        use_external_legality = 1'b0;
    endtask
    task automatic t_timeout();
        logic ok;
        int n;
        grant_block = 1'b1;
        open_msg(12'h065, 1'b1);
        push(1'b1, ACCESS_STATUS, 11'h060, 16'h0f0f, 300, ok);
        access_valid = 1'b0;
        for (n = 0; n < 130 && !backend_timeout_flag; n++) tick();
        check({15'h0, n >= 95 && n <= 110}, 16'h0001);
        check({15'h0, backend_write_strobe_n}, 16'h0001);
        clear_failure = 1'b1;
        repeat (3) tick();
        clear_failure = 1'b0;
        tick();
        check({15'h0, backend_timeout_flag}, 16'h0000);
        grant_block = 1'b0;
        close_msg();
    endtask
    task automatic t_fifo();
        logic ok;
        int n, base;
        asynchronous_mode = 1'b1;
        wait_cycles = 4'h2;
        grant_block = 1'b1;
        base = n_writes;
        open_msg(12'h065, 1'b1);
        n = 0;
        ok = 1'b1;
        while (ok && n < 20) begin
            push(1'b1, ACCESS_DATA, 11'(64 + n), 16'(16'hb000 + n), 1, ok);
            if (ok) n++;
        end
        access_valid = 1'b0;
        check({15'h0, n >= 16 && n <= 17}, 16'h0001);
        grant_block = 1'b0;
        for (int i = 0; i < 2000 && n_writes - base < n; i++) tick();
        check(16'(n_writes - base), 16'(n));
        check(model_u.mem[64 + n - 1], 16'(16'hb000 + n - 1));
        close_msg();
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clock);
            cycles++;
            if (cycles == 20000) begin
                mismatches++;
                give_verdict();
            end
        end
    end
    initial begin
        {rst_n, use_external_legality, asynchronous_mode, command_strobe} = 4'h0;
        {message_done, access_valid, access_write, clear_failure, grant_block} = 5'h00;
        {command_in, access_type, access_address, access_data} = 41'h0;
        wait_cycles = 4'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) tick();
        t_internal();
        t_access(1'b0, 4'h0, 16);
        t_access(1'b1, 4'h3, 32);
        t_external();
        t_timeout();
        t_fifo();
        give_verdict();
    end
endmodule
